// ===== verilog/plee_core.sv
// Purpose: Compiles and repeatedly evaluates a postfix list of logic entries.
// Assumes: One entry per clock; the list is rewritten only through the programming port.
// Notes: A compile walk checks syntax before any evaluation pass is allowed to run.
`timescale 1ns/1ps
module plee_core #(
    parameter int LIST_DEPTH = plee_pkg::LIST_DEPTH,
    parameter int STACK_DEPTH = 32,
    parameter int LATCH_COUNT = 16,
    parameter int VIN_COUNT = 64,
    parameter int CONTACT_COUNT = 16,
    parameter int DIG_COUNT = 16,
    parameter int PASS_BUDGET = plee_pkg::PASS_BUDGET_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // List programming
    input wire logic prog_we,
    input wire logic [$clog2(LIST_DEPTH)-1:0] prog_addr,
    input wire logic [3:0] prog_op,
    input wire logic [plee_pkg::ARG_W-1:0] prog_arg,
    // Operand sources
    input wire logic [VIN_COUNT-1:0] virtual_input,
    input wire logic [CONTACT_COUNT-1:0] contact_input_operand,
    input wire logic [CONTACT_COUNT-1:0] contact_on_closed,
    input wire logic [DIG_COUNT-1:0] digital_element_operand,
    input wire logic [plee_pkg::TIMER_COUNT-1:0] timer_state,
    // Results and status
    output logic [plee_pkg::VOUT_COUNT-1:0] virtual_output,
    output logic [plee_pkg::TIMER_COUNT-1:0] timer_start,
    output logic syntax_error,
    output logic [$clog2(LIST_DEPTH)-1:0] fault_entry,
    output logic running,
    output logic pass_done
);

    localparam int IW = $clog2(LIST_DEPTH);
    localparam int DW = $clog2(STACK_DEPTH + 1);
    localparam int LW = $clog2(LATCH_COUNT) + 1;
    localparam int VOW = $clog2(plee_pkg::VOUT_COUNT);
    localparam int TMW = $clog2(plee_pkg::TIMER_COUNT);
    localparam int VIW = $clog2(VIN_COUNT);
    localparam int CIW = $clog2(CONTACT_COUNT);
    localparam int DEW = $clog2(DIG_COUNT);
    localparam int MW = 16;
    localparam logic [IW-1:0] LAST_INDEX = IW'(LIST_DEPTH - 1);

    plee_pkg::plee_state_type state, next_state;
    logic [plee_pkg::ENTRY_W-1:0] list_mem [LIST_DEPTH];
    logic [IW-1:0] index, next_index;
    logic [STACK_DEPTH-1:0] stack, next_stack;
    logic [DW-1:0] depth, next_depth;
    logic [LW-1:0] latch_idx, next_latch_idx;
    logic [LATCH_COUNT-1:0] latch_q, next_latch_q;
    logic [plee_pkg::VOUT_COUNT-1:0] next_vout;
    logic [plee_pkg::TIMER_COUNT-1:0] next_tstart;
    logic [plee_pkg::VOUT_COUNT-1:0] assign_used, next_assign_used;
    logic [plee_pkg::TIMER_COUNT-1:0] timer_used, next_timer_used;
    logic next_err;
    logic [IW-1:0] next_fault;
    logic next_pass_done;
    logic [plee_pkg::PASS_CNT_W-1:0] pass_cycles, next_pass_cycles;

    logic [plee_pkg::ENTRY_W-1:0] cur;
    plee_pkg::plee_op_type cur_op;
    logic [plee_pkg::ARG_W-1:0] cur_arg;
    logic [MW-1:0] need, depth_w, after;
    logic result, gate_result, bad, last, latch_cur, top_bit, dup_hit;
    logic [STACK_DEPTH-1:0] shifted;

    assign cur = list_mem[index];
    assign cur_op = plee_pkg::plee_op_type'(cur[plee_pkg::OP_MSB:plee_pkg::OP_LSB]);
    assign cur_arg = cur[plee_pkg::ARG_MSB:0];
    assign top_bit = stack[0];
    assign running = (state == plee_pkg::ST_RUN);
    assign depth_w = MW'(depth);
    assign latch_cur = latch_q[latch_idx[LW-2:0]];
    assign dup_hit = (cur_op == plee_pkg::OP_ASSIGN) ? assign_used[cur_arg[VOW-1:0]]
                   : (cur_op == plee_pkg::OP_TIMER) ? timer_used[cur_arg[TMW-1:0]] : 1'b0;

    // Gates only ever see the newest GATE_MAX results.
    plee_gate #(
        .MAX_IN(plee_pkg::GATE_MAX),
        .CW(plee_pkg::ARG_W)
    ) u_gate (
        .op(cur_op),
        .count(cur_arg),
        .bits(stack[plee_pkg::GATE_MAX-1:0]),
        .result(gate_result)
    );

    // Reset fills the list with end-of-list entries; a new setting rewrites only one entry.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LIST_DEPTH; i++) begin
                list_mem[i] <= {plee_pkg::OP_END, plee_pkg::ARG_W'(0)};
            end
        end else if (prog_we) begin
            list_mem[prog_addr] <= {prog_op, prog_arg};
        end
    end

    // Operand decode, consumption count and syntax checks for the current entry.
    always_comb begin
        result = 1'b0;
        need = '0;
        bad = 1'b0;
        unique case (cur_op)
            plee_pkg::OP_END: result = 1'b0;
            plee_pkg::OP_ON: result = 1'b1;
            plee_pkg::OP_OFF: result = 1'b0;
            plee_pkg::OP_VOUT_REF: begin
                // Reads the held value, so a forward reference sees the previous pass.
                result = virtual_output[cur_arg[VOW-1:0]];
                bad = (cur_arg >= plee_pkg::ARG_W'(plee_pkg::VOUT_COUNT));
            end
            plee_pkg::OP_VIN_REF: begin
                result = virtual_input[cur_arg[VIW-1:0]];
                bad = (cur_arg >= plee_pkg::ARG_W'(VIN_COUNT));
            end
            plee_pkg::OP_CONTACT: begin
                result = contact_on_closed[cur_arg[CIW-1:0]] ?
                         contact_input_operand[cur_arg[CIW-1:0]] :
                         !contact_input_operand[cur_arg[CIW-1:0]];
                bad = (cur_arg >= plee_pkg::ARG_W'(CONTACT_COUNT));
            end
            plee_pkg::OP_DIGELEM: begin
                result = digital_element_operand[cur_arg[DEW-1:0]];
                bad = (cur_arg >= plee_pkg::ARG_W'(DIG_COUNT));
            end
            plee_pkg::OP_NOT: begin
                need = MW'(plee_pkg::SINGLE_INPUT);
                result = !top_bit;
            end
            plee_pkg::OP_OR, plee_pkg::OP_AND, plee_pkg::OP_NOR, plee_pkg::OP_NAND: begin
                need = MW'(cur_arg);
                result = gate_result;
                bad = (cur_arg < plee_pkg::ARG_W'(plee_pkg::GATE_MIN)) ||
                      (cur_arg > plee_pkg::ARG_W'(plee_pkg::GATE_MAX));
            end
            plee_pkg::OP_XOR: begin
                need = MW'(cur_arg);
                result = gate_result;
                bad = (cur_arg != plee_pkg::ARG_W'(plee_pkg::XOR_INPUTS));
            end
            plee_pkg::OP_LATCH: begin
                need = MW'(plee_pkg::LATCH_INPUTS);
                // Reset-dominant: stack[0] is reset, stack[1] is set.
                result = !stack[0] && (stack[1] || latch_cur);
                bad = (latch_idx >= LW'(LATCH_COUNT));
            end
            plee_pkg::OP_TIMER: begin
                need = MW'(plee_pkg::SINGLE_INPUT);
                result = timer_state[cur_arg[TMW-1:0]];
                bad = (cur_arg >= plee_pkg::ARG_W'(plee_pkg::TIMER_COUNT)) || dup_hit;
            end
            plee_pkg::OP_ASSIGN: begin
                need = MW'(plee_pkg::SINGLE_INPUT);
                // A leftover result would be a second consumer path, so it is refused.
                bad = (cur_arg >= plee_pkg::ARG_W'(plee_pkg::VOUT_COUNT)) || dup_hit ||
                      (depth_w != MW'(plee_pkg::SINGLE_INPUT));
            end
        endcase
        bad = bad || (depth_w < need);
        after = (cur_op == plee_pkg::OP_ASSIGN) ? '0 : MW'(depth_w - need + 1'b1);
        bad = bad || (cur_op != plee_pkg::OP_END && after > MW'(STACK_DEPTH));
        last = (cur_op == plee_pkg::OP_END) || (index == LAST_INDEX);
        shifted = stack >> need;
    end

    // Sequencer: compile walk, evaluation passes and the fault hold.
    always_comb begin
        next_state = state;
        next_index = index;
        next_stack = stack;
        next_depth = depth;
        next_latch_idx = latch_idx;
        next_latch_q = latch_q;
        next_vout = virtual_output;
        next_tstart = timer_start;
        next_assign_used = assign_used;
        next_timer_used = timer_used;
        next_err = syntax_error;
        next_fault = fault_entry;
        next_pass_done = 1'b0;
        next_pass_cycles = pass_cycles;
        unique case (state)
            plee_pkg::ST_COMPILE: begin
                if (cur_op != plee_pkg::OP_END && bad) begin
                    next_state = plee_pkg::ST_FAULT;
                    next_err = 1'b1;
                    next_fault = index;
                end else begin
                    next_depth = DW'(after);
                    if (cur_op == plee_pkg::OP_ASSIGN) begin
                        next_assign_used[cur_arg[VOW-1:0]] = 1'b1;
                    end
                    if (cur_op == plee_pkg::OP_TIMER) begin
                        next_timer_used[cur_arg[TMW-1:0]] = 1'b1;
                    end
                    if (cur_op == plee_pkg::OP_LATCH) begin
                        next_latch_idx = LW'(latch_idx + 1'b1);
                    end
                    next_index = IW'(index + 1'b1);
                    if (last) begin
                        next_state = plee_pkg::ST_RUN;
                        next_index = '0;
                        next_depth = '0;
                        next_latch_idx = '0;
                        next_pass_cycles = '0;
                    end
                end
            end
            plee_pkg::ST_RUN: begin
                if (pass_cycles != '1) begin
                    next_pass_cycles = plee_pkg::PASS_CNT_W'(pass_cycles + 1'b1);
                end
                if (cur_op != plee_pkg::OP_END) begin
                    // Results land on the stack at once for later entries.
                    next_stack = {shifted[STACK_DEPTH-2:0], result};
                    next_depth = DW'(after);
                    if (cur_op == plee_pkg::OP_LATCH) begin
                        next_latch_q[latch_idx[LW-2:0]] = result;
                        next_latch_idx = LW'(latch_idx + 1'b1);
                    end
                    if (cur_op == plee_pkg::OP_TIMER) begin
                        next_tstart[cur_arg[TMW-1:0]] = top_bit;
                    end
                    if (cur_op == plee_pkg::OP_ASSIGN) begin
                        next_vout[cur_arg[VOW-1:0]] = top_bit;
                        next_stack = '0;
                    end
                end
                next_index = IW'(index + 1'b1);
                if (last) begin
                    next_index = '0;
                    next_stack = '0;
                    next_depth = '0;
                    next_latch_idx = '0;
                    next_pass_done = 1'b1;
                    next_pass_cycles = '0;
                end
            end
            plee_pkg::ST_FAULT: begin
                next_state = plee_pkg::ST_FAULT;
            end
            default: begin
                next_state = plee_pkg::ST_COMPILE;
                next_index = '0;
            end
        endcase
        // A new setting throws away all evaluation state and starts a fresh compile.
        if (prog_we) begin
            next_state = plee_pkg::ST_COMPILE;
            next_index = '0;
            next_stack = '0;
            next_depth = '0;
            next_latch_idx = '0;
            next_latch_q = '0;
            next_vout = '0;
            next_tstart = '0;
            next_assign_used = '0;
            next_timer_used = '0;
            next_err = 1'b0;
            next_fault = '0;
            next_pass_done = 1'b0;
            next_pass_cycles = '0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= plee_pkg::ST_COMPILE;
            index <= '0;
            stack <= '0;
            depth <= '0;
            latch_idx <= '0;
            latch_q <= '0;
            virtual_output <= '0;
            timer_start <= '0;
            assign_used <= '0;
            timer_used <= '0;
            syntax_error <= 1'b0;
            fault_entry <= '0;
            pass_done <= 1'b0;
            pass_cycles <= '0;
        end else begin
            state <= next_state;
            index <= next_index;
            stack <= next_stack;
            depth <= next_depth;
            latch_idx <= next_latch_idx;
            latch_q <= next_latch_q;
            virtual_output <= next_vout;
            timer_start <= next_tstart;
            assign_used <= next_assign_used;
            timer_used <= next_timer_used;
            syntax_error <= next_err;
            fault_entry <= next_fault;
            pass_done <= next_pass_done;
            pass_cycles <= next_pass_cycles;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic run_live;
    assign run_live = running && !prog_we;

    sequence s_run_op(plee_pkg::plee_op_type o);
        run_live && cur_op == o;
    endsequence

    sequence s_compile_op(plee_pkg::plee_op_type o);
        state == plee_pkg::ST_COMPILE && !prog_we && cur_op == o;
    endsequence

    property p_assign_stores;
        s_run_op(plee_pkg::OP_ASSIGN)
            |=> virtual_output[$past(cur_arg[VOW-1:0])] == $past(top_bit) && depth == '0;
    endproperty
    a_assign_stores: assert property (p_assign_stores) else $error("no store");
    property p_recompile;
        prog_we |=> state == plee_pkg::ST_COMPILE && latch_q == '0 && index == '0 && !syntax_error;
    endproperty
    a_recompile: assert property (p_recompile) else $error("no restart");
    property p_latch_reset_dom;
        s_run_op(plee_pkg::OP_LATCH) and (top_bit == 1'b1) |=> stack[0] == 1'b0;
    endproperty
    a_latch_reset_dom: assert property (p_latch_reset_dom) else $error("set won");
    property p_latch_set;
        s_run_op(plee_pkg::OP_LATCH) and (stack[1:0] == 2'b10) |=> stack[0] == 1'b1;
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("latch did not set");
    property p_not;
        s_run_op(plee_pkg::OP_NOT) |=> stack[0] == !$past(top_bit) && depth == $past(depth);
    endproperty
    a_not: assert property (p_not) else $error("inverter wrong");
    property p_dup;
        s_compile_op(plee_pkg::OP_ASSIGN) and dup_hit
            |=> state == plee_pkg::ST_FAULT && syntax_error ##1 syntax_error;
    endproperty
    a_dup: assert property (p_dup) else $error("duplicate accepted");
    property p_underflow;
        state == plee_pkg::ST_COMPILE && !prog_we && cur_op != plee_pkg::OP_END && depth_w < need
            |=> syntax_error && fault_entry == $past(index);
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow accepted");
    property p_gate_depth;
        run_live && (cur_op == plee_pkg::OP_AND || cur_op == plee_pkg::OP_OR)
            |=> MW'(depth) == MW'($past(depth_w) - $past(need) + 1'b1);
    endproperty
    a_gate_depth: assert property (p_gate_depth) else $error("bad consume count");
    property p_end_wraps;
        s_run_op(plee_pkg::OP_END) |=> index == '0 && pass_done && depth == '0;
    endproperty
    a_end_wraps: assert property (p_end_wraps) else $error("no wrap at end");
    property p_pass_budget;
        running |-> pass_cycles <= plee_pkg::PASS_CNT_W'(PASS_BUDGET);
    endproperty
    a_pass_budget: assert property (p_pass_budget) else $error("pass too slow");

endmodule

// ===== verilog/plee_pkg.sv
// Purpose: Shared constants and types for the postfix logic equation evaluator.
// Assumes: One 10 MHz clock; the list is written through a plain programming port.
// Notes: Each list entry is an operator code and an 8-bit argument.
// Operation
// - Operators take inputs only from results produced earlier in the list.
// - Each operator yields one result, consumed by at most one later operator.
// - Assigning to a virtual output ends the equation; next entry starts afresh.
// - Duplicate timer use or duplicate virtual output assignment is a syntax error.
// - Entries are evaluated in stored order; results serve later entries same pass.
// - Latches hold set state and are cleared on power-up.
// - Any new setting recompiles the list and clears every latch.
// - Virtual outputs 1 to 64 exist, each assignable only once.
// - Gate input count is explicit, at most 16; wider functions cascade gates.
// - A gate with N inputs consumes the N latest results; nearest is lowest.
// - Inverter takes the single preceding result and outputs its complement.
// - Latch takes two results: nearest is reset, the one before is set.
// - Timer takes the preceding result as start; delays come from timer configuration.
// - The whole list is evaluated at least four times per power cycle.
// - Referencing a virtual output before its assignment is valid feedback.
// - Contact operand ON state is selectable for open or closed contact.
// - Latch is reset-dominant: set and reset together give a low output.
// - Each pass stops at the first end-of-list entry.
package plee_pkg;

    localparam int ENTRY_W = 12;
    localparam int OP_MSB = 11;
    localparam int OP_LSB = 8;
    localparam int ARG_MSB = 7;
    localparam int ARG_W = 8;
    localparam int LIST_DEPTH = 512;
    localparam int VOUT_COUNT = 64;
    localparam int TIMER_COUNT = 32;
    localparam int GATE_MIN = 2;
    localparam int GATE_MAX = 16;
    localparam int XOR_INPUTS = 2;
    localparam int LATCH_INPUTS = 2;
    localparam int SINGLE_INPUT = 1;

    // Pass rate figures: passes per power-frequency cycle and the highest supported frequency.
    localparam int CLK_HZ = 10000000;
    localparam int POWER_FREQ_HZ = 60;
    localparam int PASSES_PER_CYCLE = 4;
    localparam int PASS_BUDGET_CYCLES = CLK_HZ / (POWER_FREQ_HZ * PASSES_PER_CYCLE);
    localparam int PASS_CNT_W = 17;

    typedef enum logic [3:0] {
        OP_END = 4'h0,
        OP_ON = 4'h1,
        OP_OFF = 4'h2,
        OP_VOUT_REF = 4'h3,
        OP_VIN_REF = 4'h4,
        OP_CONTACT = 4'h5,
        OP_DIGELEM = 4'h6,
        OP_NOT = 4'h7,
        OP_OR = 4'h8,
        OP_AND = 4'h9,
        OP_NOR = 4'ha,
        OP_NAND = 4'hb,
        OP_XOR = 4'hc,
        OP_LATCH = 4'hd,
        OP_TIMER = 4'he,
        OP_ASSIGN = 4'hf
    } plee_op_type;

    typedef enum logic [1:0] {
        ST_COMPILE = 2'b00,
        ST_RUN = 2'b01,
        ST_FAULT = 2'b11
    } plee_state_type;

endpackage

// ===== verilog/plee_gate.sv
// Purpose: Multi-input gate over the newest results of the evaluation stack.
// Assumes: Bit 0 of bits is the result just before the gate.
// Notes: Inputs at or above count are ignored.
`timescale 1ns/1ps
module plee_gate #(
    parameter int MAX_IN = plee_pkg::GATE_MAX,
    parameter int CW = plee_pkg::ARG_W
) (
    // Gate selection
    input wire plee_pkg::plee_op_type op,
    input wire logic [CW-1:0] count,
    // Operands and result
    input wire logic [MAX_IN-1:0] bits,
    output logic result
);

    logic [CW-1:0] ones;

    always_comb begin
        ones = '0;
        for (int i = 0; i < MAX_IN; i++) begin
            if (CW'(i) < count && bits[i]) begin
                ones = CW'(ones + 1'b1);
            end
        end
    end

    always_comb begin
        unique case (op)
            plee_pkg::OP_OR: result = (ones != '0);
            plee_pkg::OP_AND: result = (ones == count);
            plee_pkg::OP_NOR: result = (ones == '0);
            plee_pkg::OP_NAND: result = (ones != count);
            plee_pkg::OP_XOR: result = (ones == CW'(1));
            default: result = 1'b0;
        endcase
    end

endmodule

// ===== dv/plee_core_tb.sv
// Purpose: Self-checking bench for the postfix logic equation evaluator core.
// Assumes: Inputs change on the falling clock edge; lists stay short.
// Notes: Each scenario loads a list, lets passes run (t_syntax waits for the compile only), then checks the outputs.
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got %h expected %h", $time, (a), (b)); end end
module plee_core_tb;
    // Stimulus and observed outputs
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic prog_we = 1'b0;
    logic [8:0] prog_addr = 9'h000;
    logic [3:0] prog_op = 4'h0;
    logic [7:0] prog_arg = 8'h00;
    logic [63:0] virtual_input = 64'h0;
    logic [15:0] contact_input_operand = 16'h0;
    logic [15:0] contact_on_closed = 16'h0;
    logic [15:0] digital_element_operand = 16'h0;
    logic [31:0] timer_state = 32'h0;
    logic [63:0] virtual_output;
    logic [31:0] timer_start;
    logic syntax_error;
    logic [8:0] fault_entry;
    logic running;
    logic pass_done;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [11:0] lst[$];

    plee_core u_dut (.clock(clock), .rst_n(rst_n), .prog_we(prog_we), .prog_addr(prog_addr),
        .prog_op(prog_op), .prog_arg(prog_arg), .virtual_input(virtual_input),
        .contact_input_operand(contact_input_operand), .contact_on_closed(contact_on_closed),
        .digital_element_operand(digital_element_operand), .timer_state(timer_state),
        .virtual_output(virtual_output), .timer_start(timer_start),
        .syntax_error(syntax_error), .fault_entry(fault_entry), .running(running),
        .pass_done(pass_done));

    initial begin
        forever #50 clock = ~clock;
    end

    // A hung wait must still end in the closing report.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("[FAIL] t=%0t timeout", $time);
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Back-to-back writes hold the strobe up; it drops one edge after the last entry.
    task automatic load();
        for (int i = 0; i < lst.size(); i++) begin
            @(negedge clock);
            prog_we = 1'b1;
            prog_addr = 9'(i);
            {prog_op, prog_arg} = lst[i];
        end
        @(negedge clock);
        prog_we = 1'b0;
    endtask

    task automatic wait_pass();
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (pass_done !== 1'b1 && n < 600);
        `CHK(pass_done, 1'b1)
    endtask

    task automatic settle(input int passes);
        int n;
        n = 0;
        while (running !== 1'b1 && syntax_error !== 1'b1 && n < 600) begin
            @(negedge clock);
            n++;
        end
        for (int p = 0; p < passes; p++) wait_pass();
    endtask

    task automatic t_gates();
        lst = '{{plee_pkg::OP_DIGELEM, 8'h02}, {plee_pkg::OP_CONTACT, 8'h00},
            {plee_pkg::OP_NOT, 8'h00}, {plee_pkg::OP_AND, 8'h02},
            {plee_pkg::OP_ASSIGN, 8'h02}, {plee_pkg::OP_END, 8'h00}};
        digital_element_operand = 16'h0004;
        contact_input_operand = 16'h0001;
        contact_on_closed = 16'h0001;
        load();
        settle(2);
        `CHK(virtual_output[2], 1'b0)
        contact_on_closed = 16'h0000;
        settle(2);
        `CHK(virtual_output[2], 1'b1)
        digital_element_operand = 16'h0000;
        settle(2);
        `CHK(virtual_output[2], 1'b0)
    endtask

    // NAND and XOR are equations of their own; NOR feeds an OR that consumes the OFF left under the NOR.
    task automatic t_gate_kinds();
        logic lo, hi;
        lst = '{{plee_pkg::OP_OFF, 8'h00}, {plee_pkg::OP_VIN_REF, 8'h00},
            {plee_pkg::OP_VIN_REF, 8'h01}, {plee_pkg::OP_NOR, 8'h02}, {plee_pkg::OP_OR, 8'h02},
            {plee_pkg::OP_ASSIGN, 8'h0a}, {plee_pkg::OP_VIN_REF, 8'h00},
            {plee_pkg::OP_VIN_REF, 8'h01}, {plee_pkg::OP_NAND, 8'h02},
            {plee_pkg::OP_ASSIGN, 8'h0b}, {plee_pkg::OP_VIN_REF, 8'h00},
            {plee_pkg::OP_VIN_REF, 8'h01}, {plee_pkg::OP_XOR, 8'h02},
            {plee_pkg::OP_ASSIGN, 8'h0c}, {plee_pkg::OP_OFF, 8'h00},
            {plee_pkg::OP_ASSIGN, 8'h0d}, {plee_pkg::OP_END, 8'h00}};
        load();
        for (int v = 0; v < 4; v++) begin
            lo = v[0];
            hi = v[1];
            virtual_input = {62'h0, hi, lo};
            settle(2);
            `CHK(virtual_output[13:10], {1'b0, lo ^ hi, !(lo && hi), !(lo || hi)})
        end
    endtask

    task automatic t_latch();
        lst = '{{plee_pkg::OP_VIN_REF, 8'h00}, {plee_pkg::OP_VIN_REF, 8'h01},
            {plee_pkg::OP_LATCH, 8'h00}, {plee_pkg::OP_ASSIGN, 8'h00},
            {plee_pkg::OP_END, 8'h00}};
        virtual_input = 64'h1;
        load();
        settle(2);
        `CHK(virtual_output[0], 1'b1)
        virtual_input = 64'h0;
        settle(2);
        `CHK(virtual_output[0], 1'b1)
        virtual_input = 64'h3;
        settle(2);
        `CHK(virtual_output[0], 1'b0)
        virtual_input = 64'h1;
        settle(2);
        virtual_input = 64'h0;
        settle(2);
        lst = '{{plee_pkg::OP_VIN_REF, 8'h00}};
        load();
        settle(2);
        `CHK(virtual_output[0], 1'b0)
    endtask

    task automatic t_timer_end();
        lst = '{{plee_pkg::OP_VIN_REF, 8'h00}, {plee_pkg::OP_TIMER, 8'h03},
            {plee_pkg::OP_ASSIGN, 8'h01}, {plee_pkg::OP_ON, 8'h00},
            {plee_pkg::OP_ASSIGN, 8'h05}, {plee_pkg::OP_END, 8'h00},
            {plee_pkg::OP_ON, 8'h00}, {plee_pkg::OP_ASSIGN, 8'h06}};
        virtual_input = 64'h1;
        timer_state = 32'h0;
        load();
        settle(2);
        `CHK(timer_start[3], 1'b1)
        `CHK(virtual_output[1], 1'b0)
        `CHK(virtual_output[6:5], 2'b01)
        timer_state = 32'h8;
        settle(2);
        `CHK(virtual_output[1], 1'b1)
    endtask

    // A self-referencing output reads the previous pass, so it flips every pass.
    task automatic t_feedback();
        lst = '{{plee_pkg::OP_VOUT_REF, 8'h00}, {plee_pkg::OP_NOT, 8'h00},
            {plee_pkg::OP_ASSIGN, 8'h00}, {plee_pkg::OP_END, 8'h00}};
        load();
        settle(1);
        `CHK(virtual_output[0], 1'b1)
        wait_pass();
        `CHK(virtual_output[0], 1'b0)
    endtask

    task automatic t_syntax();
        logic [11:0] bad[6][8];
        int at[6];
        bad[0] = '{{plee_pkg::OP_ON, 8'h00}, {plee_pkg::OP_ASSIGN, 8'h00},
            {plee_pkg::OP_ON, 8'h00}, {plee_pkg::OP_ASSIGN, 8'h00}, 12'h0, 12'h0, 12'h0, 12'h0};
        bad[1] = '{{plee_pkg::OP_ON, 8'h00}, {plee_pkg::OP_TIMER, 8'h03},
            {plee_pkg::OP_ASSIGN, 8'h00}, {plee_pkg::OP_ON, 8'h00},
            {plee_pkg::OP_TIMER, 8'h03}, {plee_pkg::OP_ASSIGN, 8'h01}, 12'h0, 12'h0};
        bad[2] = '{{plee_pkg::OP_ON, 8'h00}, {plee_pkg::OP_ON, 8'h00},
            {plee_pkg::OP_OR, 8'h11}, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0};
        bad[3] = '{{plee_pkg::OP_NOT, 8'h00}, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0, 12'h0};
        bad[4] = '{{plee_pkg::OP_ON, 8'h00}, {plee_pkg::OP_ASSIGN, 8'h40}, 12'h0, 12'h0, 12'h0,
            12'h0, 12'h0, 12'h0};
        bad[5] = '{{plee_pkg::OP_ON, 8'h00}, {plee_pkg::OP_OR, 8'h01}, 12'h0, 12'h0, 12'h0,
            12'h0, 12'h0, 12'h0};
        at = '{3, 4, 2, 0, 1, 1};
        for (int k = 0; k < 6; k++) begin
            lst = {};
            for (int i = 0; i < 8; i++) lst.push_back(bad[k][i]);
            load();
            settle(0);
            `CHK(syntax_error, 1'b1)
            `CHK(fault_entry, 9'(at[k]))
            `CHK(running, 1'b0)
        end
    endtask

    initial begin
        repeat (20) @(negedge clock);
        `CHK(virtual_output, 64'h0)
        `CHK(running, 1'b0)
        rst_n = 1'b1;
        repeat (4) @(negedge clock);
        `CHK(running, 1'b1)
        t_gates();
        t_gate_kinds();
        t_latch();
        t_timer_end();
        t_feedback();
        t_syntax();
        give_verdict();
    end
endmodule
